// File: hw/fsrw_pkg.sv
// Purpose: Shared constants and types for the flash self read/write controller
// Assumes: 250 MHz aclk, 32-bit AXI4-Lite register access
// Notes: Byte offsets of the register words live here

package fsrw_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned CNT_W = 20;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 10'h3FF;
  localparam logic [1:0] BLOCK_LAST = 2'h3;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DATA_LOW = 8'h00;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned CTL_RD_BIT = 0;
  localparam int unsigned CTL_WR_BIT = 1;
  localparam int unsigned CTL_WEN_BIT = 2;
  localparam int unsigned CFG_WP_LSB = 0;
  localparam int unsigned CFG_CP_BIT = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] WP_RESET = 2'h3;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ERASE_TIME_US = 4000;
  localparam int unsigned PROG_TIME_US = 2000;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_GAP = 3'b001,
    ST_RD_ACC = 3'b010,
    ST_ERASE = 3'b011,
    ST_PROG = 3'b100,
    ST_BUF = 3'b101
  } fsrw_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic read;
    logic erase;
    logic prog;
  } fsrw_flash_req_t;

endpackage

// File: hw/fsrw_ctrl.sv
// Purpose: Flash self read/write sequencer behind an AXI4-Lite register file
// Assumes: Flash macro answers reads combinationally; erase clears a 16-word row
// Notes: Erase and program durations are parameters so simulation can shorten them
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.

`timescale 1ns/1ps

module fsrw_ctrl
  import fsrw_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_CYCLES,
  parameter int unsigned PROG_CYC = PROG_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output fsrw_flash_req_t flash_req,
  input wire logic [WORD_W-1:0] flash_rdata,
  output logic instr_discard,
  output logic core_halt,
  output logic serial_access_allow
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  fsrw_state_t state, next_state;
  logic [7:0] data_low, addr_low;
  logic [5:0] data_high;
  logic [1:0] addr_high, wp_sel, widx;
  logic rd_bit, wr_bit, wen_bit, cp_bit;
  logic key_got_first, key_armed;
  logic [CNT_W-1:0] cnt;
  logic [WORD_W-1:0] wbuf [4];
  logic aw_held, w_held, wb_en;
  logic [7:0] aw_q, wb;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic do_wr = aw_held && w_held && !bvalid;
  wire logic sel_dl = (aw_q == OFS_DATA_LOW);
  wire logic sel_dh = (aw_q == OFS_DATA_HIGH);
  wire logic sel_al = (aw_q == OFS_ADDR_LOW);
  wire logic sel_ah = (aw_q == OFS_ADDR_HIGH);
  wire logic sel_ctl = (aw_q == OFS_CONTROL);
  wire logic sel_key = (aw_q == OFS_UNLOCK_KEY);
  wire logic sel_cfg = (aw_q == OFS_CONFIG);
  wire logic wr_hit = sel_dl | sel_dh | sel_al | sel_ah | sel_ctl | sel_key | sel_cfg;
  wire logic wr_go = do_wr && wb_en;
  wire logic [ADDR_W-1:0] word_addr = {addr_high, addr_low};
  wire logic [WORD_W-1:0] word_data = {data_high, data_low};

  // Strobed start requests; clears written as zero simply do nothing
  wire logic ctl_wr = wr_go && sel_ctl && (state == ST_IDLE);
  wire logic wr_req = ctl_wr && wb[CTL_WR_BIT] && wen_bit && key_armed;
  wire logic rd_go = ctl_wr && wb[CTL_RD_BIT] && !wr_req;

  // Region lock: 11 none, 10 lower quarter, 01 lower half, 00 all
  wire logic prot_hit = (wp_sel == 2'h0)
                     || (wp_sel == 2'h1 && !word_addr[9])
                     || (wp_sel == 2'h2 && word_addr[9:8] == 2'h0);
  wire logic block_go = wr_req && (addr_low[1:0] == BLOCK_LAST) && !prot_hit;
  wire logic cnt_done = (cnt == '0);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic rd_hit = (araddr <= OFS_CONFIG) && (araddr[1:0] == 2'h0); // Dense word map
  wire logic [7:0] rd_val =
      (araddr == OFS_DATA_LOW)  ? data_low :
      (araddr == OFS_DATA_HIGH) ? {2'h0, data_high} :
      (araddr == OFS_ADDR_LOW)  ? addr_low :
      (araddr == OFS_ADDR_HIGH) ? {6'h00, addr_high} :
      (araddr == OFS_CONTROL)   ? {5'h00, wen_bit, wr_bit, rd_bit} :
      (araddr == OFS_CONFIG)    ? {5'h00, cp_bit, wp_sel} :
      8'h00;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  // ----------------------------------------
  // Flash side outputs
  // ----------------------------------------
  // Access paths ignore cp_bit so the core keeps full reach when protected
  always_comb
  begin
    flash_req.addr = word_addr;
    flash_req.wdata = wbuf[widx];
    flash_req.read = (state == ST_RD_ACC);
    flash_req.erase = (state == ST_ERASE);
    flash_req.prog = (state == ST_PROG);
    if (state == ST_PROG)
    begin
      flash_req.addr = {word_addr[ADDR_W-1:2], widx};
    end
  end

  assign instr_discard = (state == ST_RD_ACC);
  assign core_halt = (state == ST_ERASE) || (state == ST_PROG);
  assign serial_access_allow = !cp_bit;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (block_go)
          next_state = ST_ERASE;
        else if (wr_req)
          next_state = ST_BUF;
        else if (rd_go)
          next_state = ST_RD_GAP;
      end
      ST_RD_GAP: next_state = ST_RD_ACC;
      ST_RD_ACC: next_state = ST_IDLE;
      ST_ERASE: next_state = cnt_done ? ST_PROG : ST_ERASE;
      ST_PROG: next_state = (cnt_done && widx == BLOCK_LAST) ? ST_IDLE : ST_PROG;
      ST_BUF: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Self-timed erase then per-word program
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {cnt, widx} <= '0;
    else if (block_go)
      cnt <= CNT_W'(ERASE_CYC - 1);
    else if (state == ST_ERASE && cnt_done)
    begin
      cnt <= CNT_W'(PROG_CYC - 1);
      widx <= 2'h0;
    end
    else if (state == ST_PROG && cnt_done)
    begin
      cnt <= CNT_W'(PROG_CYC - 1);
      widx <= widx + 2'h1;
    end
    else if (!cnt_done)
      cnt <= cnt - CNT_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (wr_req)
      wbuf[addr_low[1:0]] <= word_data;
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  // Read and write start bits set-only from software; a zero write never aborts a running operation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {wen_bit, wr_bit, rd_bit} <= 3'b000;
    else
    begin
      if (wr_go && sel_ctl)
        wen_bit <= wb[CTL_WEN_BIT];
      if (rd_go)
        rd_bit <= 1'b1;
      else if (state == ST_RD_ACC)
        rd_bit <= 1'b0;
      if (wr_req)
        wr_bit <= 1'b1;
      else if (next_state == ST_IDLE)
        wr_bit <= 1'b0;
    end
  end

  // Unlock pair must be the last two writes before the start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {key_got_first, key_armed} <= 2'b00;
    else if (wr_go)
    begin
      key_got_first <= sel_key && (wb == KEY_FIRST);
      key_armed <= sel_key && key_got_first && (wb == KEY_SECOND);
    end
  end

  // ----------------------------------------
  // Data, address and config registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_low <= REG_RESET;
      data_high <= REG_RESET[5:0];
      addr_low <= REG_RESET;
      addr_high <= REG_RESET[1:0];
      {cp_bit, wp_sel} <= {1'b0, WP_RESET};
    end
    else
    begin
      if (state == ST_RD_ACC)
        {data_high, data_low} <= flash_rdata;
      else
      begin
        if (wr_go && sel_dl)
          data_low <= wb;
        if (wr_go && sel_dh)
          data_high <= wb[5:0];
      end
      if (wr_go && sel_al && state == ST_IDLE)
        addr_low <= wb;
      if (wr_go && sel_ah && state == ST_IDLE)
        addr_high <= wb[1:0];
      if (wr_go && sel_cfg)
        {cp_bit, wp_sel} <= {wb[CFG_CP_BIT], wb[CFG_WP_LSB +: 2]};
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      wb <= 8'h00;
      wb_en <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        wb <= wdata[7:0];
        wb_en <= wstrb[0];
      end
      if (do_wr)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_val};
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_slot;
    !flash_req.read ##1 (flash_req.read && instr_discard);
  endsequence
  rd_slot_a: assert property (rd_go |=> s_rd_slot ##1 !rd_bit)
    else $error("read access slot or read start clear wrong");
  rd_data_a: assert property (flash_req.read |=> word_data == $past(flash_rdata))
    else $error("read word not in data registers");
  data_hold_a: assert property ((state == ST_IDLE && !wr_go) |=> $stable(word_data))
    else $error("data registers changed without read or write");
  wr_busy_a: assert property (core_halt |-> wr_bit)
    else $error("write start low during operation");
  erase_gate_a: assert property ($rose(flash_req.erase) |->
      $past(wen_bit) && $past(key_armed))
    else $error("erase started without write allow and unlock");
  erase_prot_a: assert property ($rose(flash_req.erase) |-> !$past(prot_hit))
    else $error("erase of a protected region");
  erase_then_prog_a: assert property ($fell(flash_req.erase) |->
      flash_req.prog && flash_req.addr[1:0] == 2'h0)
    else $error("program does not follow erase at group start");
  wr_sticky_a: assert property ((wr_go && sel_ctl && state == ST_ERASE) |=> wr_bit)
    else $error("software cleared write start");
  cp_port_a: assert property (cp_bit |-> !serial_access_allow)
    else $error("serial port allowed under code protection");
  bresp_hold_a: assert property ((bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

endmodule

// File: sim/fsrw_flash_model.sv
// Purpose: Flash array stand-in facing the sequencer
// Assumes: Erased cells read all ones
// Notes: Idle read bus shows junk, which stays all zeros, not the last word
`timescale 1ns/1ps
module fsrw_flash_model
  import fsrw_pkg::*;
(
  input wire logic aclk,
  input wire fsrw_flash_req_t req,
  output logic [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] mem [0:1023];
  logic [WORD_W-1:0] junk = '0;
  // ----------------------------------------
  // Array
  // ----------------------------------------
  // Stale data would hide a late capture, so idle reads show junk, which never leaves zero
  assign rdata = req.read ? mem[req.addr] : junk;
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 14'h3FFF;
  end
  always @(posedge aclk)
  begin
    junk <= ~junk + 14'h0001;
    if (req.erase)
      for (int i = 0; i < 16; i++)
        mem[{req.addr[ADDR_W-1:4], i[3:0]}] <= 14'h3FFF;
    if (req.prog)
      mem[req.addr] <= req.wdata;
  end
endmodule

// File: sim/fsrw_ctrl_tb.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short erase and program counts
// Notes: Bench samples ready flags at the falling edge
`timescale 1ns/1ps
module fsrw_ctrl_tb
  import fsrw_pkg::*;
;
  localparam int ECYC = 8;
  localparam int PCYC = 6;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic instr_discard, core_halt, serial_access_allow;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  fsrw_flash_req_t flash_req;
  logic [WORD_W-1:0] flash_rdata;
  logic [ADDR_W-1:0] rd_at = '0;
  int bad_count = 0, checks = 0;
  int er_n = 0, pr_n = 0, rd_n = 0, dis_n = 0, skew_n = 0;

  fsrw_ctrl #(.ERASE_CYC(ECYC), .PROG_CYC(PCYC)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .flash_req(flash_req), .flash_rdata(flash_rdata),
    .instr_discard(instr_discard), .core_halt(core_halt),
    .serial_access_allow(serial_access_allow));
  fsrw_flash_model fm (.aclk(aclk), .req(flash_req), .rdata(flash_rdata));

  initial
  begin
    forever #2 aclk = ~aclk;
  end
  // ----------------------------------------
  // Flash side monitor
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (aresetn)
    begin
      er_n <= er_n + int'(flash_req.erase);
      pr_n <= pr_n + int'(flash_req.prog);
      rd_n <= rd_n + int'(flash_req.read);
      dis_n <= dis_n + int'(instr_discard);
      skew_n <= skew_n + int'(instr_discard !== flash_req.read);
      if (flash_req.read)
        rd_at <= flash_req.addr;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 200)
    begin
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    int n;
    n = 0;
    bh = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid === 1'b1;
      resp = bresp;
      @(posedge aclk);
      awvalid <= awvalid && !ah;
      wvalid <= wvalid && !wh;
      tick(n);
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ah, rh;
    int n;
    n = 0;
    rh = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid === 1'b1;
      got = rdata;
      resp = rresp;
      @(posedge aclk);
      arvalid <= arvalid && !ah;
      tick(n);
    end
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    axi_rd(a);
    chk(got, {24'h000000, e}, "reg");
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "resp");
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    axi_wr(a, d);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "wresp");
    rd_chk(a, e);
  endtask
  task automatic set_addr(input logic [ADDR_W-1:0] a);
    axi_wr(OFS_ADDR_HIGH, {6'h00, a[9:8]});
    axi_wr(OFS_ADDR_LOW, a[7:0]);
  endtask
  task automatic flash_read(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
    int r0, d0;
    r0 = rd_n;
    d0 = dis_n;
    set_addr(a);
    axi_wr(OFS_CONTROL, 8'h01);
    repeat (4) @(posedge aclk);
    chk(rd_n - r0, 1, "reads");
    chk(dis_n - d0, 1, "slot");
    chk({22'h0, rd_at}, {22'h0, a}, "addr");
    rd_chk(OFS_DATA_LOW, e[7:0]);
    rd_chk(OFS_DATA_HIGH, {2'b00, e[13:8]});
    rd_chk(OFS_CONTROL, 8'h00);
  endtask
  task automatic wr_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    set_addr(a);
    axi_wr(OFS_DATA_LOW, d[7:0]);
    axi_wr(OFS_DATA_HIGH, {2'b00, d[13:8]});
    axi_wr(OFS_CONTROL, 8'h04);
    axi_wr(OFS_UNLOCK_KEY, KEY_FIRST);
    axi_wr(OFS_UNLOCK_KEY, KEY_SECOND);
    axi_wr(OFS_CONTROL, 8'h06);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    got = 32'h2;
    while (got[1] !== 1'b0)
    begin
      axi_rd(OFS_CONTROL);
      tick(n);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({31'h0, serial_access_allow}, 1, "pin");
    rd_chk(OFS_DATA_LOW, 8'h00);
    rd_chk(OFS_DATA_HIGH, 8'h00);
    rd_chk(OFS_ADDR_LOW, 8'h00);
    rd_chk(OFS_ADDR_HIGH, 8'h00);
    rd_chk(OFS_CONTROL, 8'h00);
    rd_chk(OFS_UNLOCK_KEY, 8'h00);
    rd_chk(OFS_CONFIG, {6'h00, WP_RESET});
    axi_rd(8'h1C);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "resp");
    chk(got, 0, "reg");
    axi_wr(8'h1C, 8'hFF);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "resp");
  endtask
  task automatic t_fields;
    wr_rd(OFS_DATA_LOW, 8'hFF, 8'hFF);
    wr_rd(OFS_DATA_HIGH, 8'hFF, 8'h3F);
    wr_rd(OFS_ADDR_LOW, 8'hFF, 8'hFF);
    wr_rd(OFS_ADDR_HIGH, 8'hFF, 8'h03);
    wr_rd(OFS_UNLOCK_KEY, 8'h12, 8'h00);
    wr_rd(OFS_CONTROL, 8'hF8, 8'h00);
    wr_rd(OFS_CONTROL, 8'h04, 8'h04);
    wr_rd(OFS_CONTROL, 8'h00, 8'h00);
  endtask
  task automatic t_read;
    fm.mem[10'h2A5] = 14'h1ABC;
    fm.mem[10'h3FF] = 14'h2C3D;
    flash_read(10'h2A5, 14'h1ABC);
    flash_read(10'h3FF, 14'h2C3D);
    rd_chk(OFS_DATA_LOW, 8'h3D);
    wr_rd(OFS_DATA_LOW, 8'h5A, 8'h5A);
    chk(skew_n, 0, "slot");
  endtask
  task automatic t_guard;
    int e0;
    e0 = er_n;
    set_addr(10'h007);
    axi_wr(OFS_CONTROL, 8'h04);
    wr_rd(OFS_CONTROL, 8'h06, 8'h04);
    axi_wr(OFS_CONTROL, 8'h00);
    axi_wr(OFS_UNLOCK_KEY, KEY_FIRST);
    axi_wr(OFS_UNLOCK_KEY, KEY_SECOND);
    wr_rd(OFS_CONTROL, 8'h02, 8'h00);
    chk(er_n - e0, 0, "erase");
  endtask
  task automatic t_group;
    int e0, p0;
    fm.mem[10'h10C] = 14'h0123;
    e0 = er_n;
    p0 = pr_n;
    for (int i = 0; i < 3; i++)
    begin
      wr_word(10'h104 + i, 14'h0111 * (i + 1));
      rd_chk(OFS_CONTROL, 8'h04);
    end
    chk(er_n - e0, 0, "erase");
    wr_word(10'h107, 14'h0444);
    rd_chk(OFS_CONTROL, 8'h06);
    @(negedge aclk);
    chk({31'h0, core_halt}, 1, "pin");
    wr_rd(OFS_CONTROL, 8'h04, 8'h06);
    wait_idle();
    @(negedge aclk);
    chk({31'h0, core_halt}, 0, "pin");
    chk(er_n - e0, ECYC, "erase");
    chk(pr_n - p0, 4 * PCYC, "prog");
    for (int i = 0; i < 4; i++)
      chk({18'h0, fm.mem[10'h104 + i]}, 14'h0111 * (i + 1), "mem");
    chk({18'h0, fm.mem[10'h10C]}, 32'h3FFF, "mem");
  endtask
  task automatic t_protect;
    int e0;
    axi_wr(OFS_CONFIG, 8'h00);
    e0 = er_n;
    wr_word(10'h107, 14'h1555);
    rd_chk(OFS_CONTROL, 8'h04);
    chk(er_n - e0, 0, "erase");
    // Lower half locked, then lower quarter locked
    axi_wr(OFS_CONFIG, 8'h01);
    wr_word(10'h107, 14'h1555);
    rd_chk(OFS_CONTROL, 8'h04);
    axi_wr(OFS_CONFIG, 8'h02);
    wr_word(10'h0F7, 14'h1555);
    rd_chk(OFS_CONTROL, 8'h04);
    chk(er_n - e0, 0, "erase");
    flash_read(10'h107, 14'h0444);
    wr_rd(OFS_CONFIG, 8'h07, 8'h07);
    @(negedge aclk);
    chk({31'h0, serial_access_allow}, 0, "pin");
    flash_read(10'h104, 14'h0111);
    wr_word(10'h107, 14'h1555);
    wait_idle();
    chk({18'h0, fm.mem[10'h107]}, 32'h1555, "mem");
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_read();
    t_guard();
    t_group();
    t_protect();
    wrap_up();
  end
endmodule
